// >>> bench/scc_core_model.sv
/* Core-side model: tallies the clock ticks the core and bus receive.
   Assumes one-cycle tick pulses synchronous to i_mclk. */
`timescale 1ns/10ps
module scc_core_model import scc_pkg::*; (
  input wire logic     i_mclk,
  input wire scc_sys_t i_sys,
  output int           o_master,
  output int           o_bus,
  output int           o_core
);
  always @(posedge i_mclk) begin
    o_master <= o_master + int'(i_sys.master);
    o_bus    <= o_bus + int'(i_sys.bus);
    o_core   <= o_core + int'(i_sys.core);
  end
endmodule : scc_core_model

// >>> bench/scc_props.sv
/* Port checker for the clock controller.
   Bound from the bench top; one clock, synchronous reset. */
`timescale 1ns/10ps
module scc_props import scc_pkg::*; (
  input wire logic       i_mclk,
  input wire logic       i_srst,
  input wire logic       i_arvalid,
  input wire logic       o_arready,
  input wire logic       o_rvalid,
  input wire logic       o_awready,
  input wire logic       o_bvalid,
  input wire logic [3:0] o_msi_range,
  input wire scc_osc_t   i_osc_tick,
  input wire scc_sys_t   o_sys,
  input wire scc_kern_t  o_kern
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  property p_rd; i_arvalid && o_arready |=> o_rvalid && !o_arready; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_bw; o_bvalid |-> !o_awready; endproperty
  a_bw: assert property (p_bw) else $error("write overlap");
  property p_rst; $fell(i_srst) |-> o_msi_range == RANGE_4MHZ && o_sys == '0; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  // PLL ticks pass the output divider register first, so they lead by two cycles
  property p_mst; o_sys.master |-> $past(i_osc_tick[7:5] != 3'h0)
    || $past(i_osc_tick.pll_vco[0], 2); endproperty
  a_mst: assert property (p_mst) else $error("master tick uncaused");
  property p_bus; o_sys.bus |-> $past(o_sys.master); endproperty
  a_bus: assert property (p_bus) else $error("bus tick uncaused");
  property p_core; o_sys.core |-> $past(o_sys.master); endproperty
  a_core: assert property (p_core) else $error("core tick uncaused");
  property p_tim; o_sys.tim1 |-> $past(o_sys.master); endproperty
  a_tim: assert property (p_tim) else $error("timer tick uncaused");
  property p_wdg; i_osc_tick.slow_int |=> o_kern.wdg; endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog tick lost");
  cover property (o_sys.bus);
  cover property (o_sys.tim1);
  cover property (o_rvalid);
endmodule : scc_props

// >>> bench/test_system_clock_controller.sv
/* Self-checking bench for the clock controller.
   Drives AXI4-Lite and oscillator ticks; scc_core_model tallies ticks. */
`timescale 1ns/10ps
module test_system_clock_controller import scc_pkg::*; ;
  logic        i_mclk = 0, i_srst = 1, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic        i_arvalid = 0, i_rready = 0, o_awready, o_wready, o_bvalid, o_arready;
  logic        o_rvalid, o_fail_irq, o_slow_ext_bypass, o_clk_out_pin, o_slow_out_pin;
  logic [7:0]  i_awaddr = '0, i_araddr = '0, o_msi_trim, run = 8'hFF;
  logic [31:0] i_wdata = '0, o_rdata, rv;
  logic [1:0]  o_bresp, o_rresp, o_slow_ext_drive, o_pll_src, rs;
  logic [3:0]  o_msi_range;
  logic [4:0]  o_rc16_trim;
  scc_osc_t    i_osc_tick = '0, i_osc_ready = 8'hFF;
  scc_sys_t    o_sys;
  scc_kern_t   o_kern;
  int          checked, miscompares, cyc, n_m, n_b, n_c, cnt[8];
  // slow periods shortened so the failure timeout stays small
  int          per[8] = '{4, 5, 50, 40, 5, 62, 16, 4};

  scc_top #(.SLOW_FAIL_CYCLES(64)) dut (
    .i_mclk, .i_srst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
    .i_wstrb(4'hF), .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_osc_tick, .i_osc_ready, .o_sys, .o_kern,
    .o_periph_tick(), .o_clk_out_pin, .o_slow_out_pin, .o_fail_irq, .o_msi_range,
    .o_msi_trim, .o_rc16_trim, .o_slow_ext_drive, .o_slow_ext_bypass, .o_pll_src);
  scc_core_model u_core (.i_mclk, .i_sys(o_sys), .o_master(n_m), .o_bus(n_b), .o_core(n_c));

  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    logic [7:0] tk;
    for (int k = 0; k < 8; k++) begin
      cnt[k] = (cnt[k] + 1) % per[k];
      tk[k] = run[k] && cnt[k] == 0;
    end
    i_osc_tick <= tk;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // bready held from the start, dropped only once bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit pa = 1, pw = 1;
    @(posedge i_mclk);
    {i_awvalid, i_wvalid, i_bready} <= 3'b111;
    i_awaddr <= a;
    i_wdata <= d;
    while (pa || pw) begin
      @(posedge i_mclk);
      if (pa && o_awready) begin
        i_awvalid <= 0;
        pa = 0;
      end
      if (pw && o_wready) begin
        i_wvalid <= 0;
        pw = 0;
      end
    end
    do @(posedge i_mclk); while (!o_bvalid);
    rs = o_bresp;
    i_bready <= 0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_mclk);
    {i_arvalid, i_rready} <= 2'b11;
    i_araddr <= a;
    do @(posedge i_mclk); while (!o_arready);
    i_arvalid <= 0;
    do @(posedge i_mclk); while (!o_rvalid);
    rv = o_rdata;
    rs = o_rresp;
    i_rready <= 0;
  endtask : rd

  task automatic t_switch;
    logic [1:0] s[5] = '{SRC_FAST, SRC_RC16, SRC_PLL, SRC_MSI, SRC_FAST};
    rd(OFS_CTRL);
    chk(rv, CTRL_RST);
    i_osc_ready.fast_ext <= 0;
    wr(OFS_CTRL, {20'h0, RANGE_4MHZ, 6'h0, SRC_FAST});
    repeat (150) @(posedge i_mclk);
    rd(OFS_STATUS);
    chk(32'(rv[1:0]), 32'(SRC_MSI));
    i_osc_ready.fast_ext <= 1;
    for (int k = 0; k < 5; k++) begin
      wr(OFS_CTRL, {20'h0, RANGE_4MHZ, 6'h0, s[k]});
      repeat (300) @(posedge i_mclk);
      rd(OFS_STATUS);
      chk(32'(rv[1:0]), 32'(s[k]));
    end
    $display("source switching done");
  endtask : t_switch

  task automatic t_presc;
    int m = n_m, b = n_b, c = n_c;
    wr(OFS_PRESC, 32'h2);
    wr(OFS_GATE, GATE_RST & ~32'h1);
    // a core tick launched before the gate landed may still reach the tally
    repeat (2) @(posedge i_mclk);
    {m, b, c} = {n_m, n_b, n_c};
    repeat (400) @(posedge i_mclk);
    {m, b, c} = {n_m - m, n_b - b, n_c - c};
    chk(32'(m + 4 >= 4 * b && m <= 4 * b + 8), 32'h1);
    chk(c, 0);
    $display("prescaler and gate done");
  endtask : t_presc

  task automatic t_cfg;
    int n[5];
    wr(OFS_TRIM, 32'h3A15);
    wr(OFS_KSEL, 32'h70);
    wr(OFS_PLLCFG, 32'h2);
    @(posedge i_mclk);
    chk(32'({o_msi_trim, 3'h0, o_rc16_trim}), 32'h3A15);
    chk(32'({o_slow_ext_bypass, o_slow_ext_drive, o_pll_src}), 32'h1E);
    // 400 cycles hold a whole number of periods of every tick source used here
    repeat (400) begin
      @(posedge i_mclk);
      n[0] += o_slow_out_pin;
      n[1] += o_kern.wdg + o_kern.rtc;
      n[2] += o_clk_out_pin;
      n[3] += o_kern.adc + o_kern.serial_audio_interface;
      n[4] += o_kern.usb_rng + o_kern.uart;
    end
    chk(n[0], 8);
    chk(n[1], 18);
    chk(n[2], 100);
    chk(n[3], 180);
    chk(n[4], 125);
    for (int r = 0; r < 12; r++) begin
      wr(OFS_CTRL, {20'h0, 4'(r), 6'h0, SRC_FAST});
      @(posedge i_mclk);
      chk(32'(o_msi_range), 32'(r));
    end
    wr(8'h20, 32'h0);
    chk(32'(rs), 32'h2);
    rd(8'h22);
    chk({rv[29:0], rs}, 32'h2);
    $display("configuration done");
  endtask : t_cfg

  task automatic t_fail;
    wr(OFS_CTRL, 32'h66C);
    run[7] <= 0;
    repeat (300) @(posedge i_mclk);
    rd(OFS_STATUS);
    chk(32'({rv[1:0], o_fail_irq}), 32'({SRC_RC16, 1'b1}));
    rd(OFS_FLAGS);
    chk(rv, 32'h1);
    run[7] <= 1;
    wr(OFS_FLAGS, 32'h1);
    @(posedge i_mclk);
    chk(32'(o_fail_irq), 32'h0);
    run[3] <= 0;
    repeat (150) @(posedge i_mclk);
    rd(OFS_FLAGS);
    chk(32'({rv[1:0], o_fail_irq}), 32'h5);
    run[3] <= 1;
    wr(OFS_FLAGS, 32'h2);
    $display("failure monitors done");
  endtask : t_fail

  task automatic close_out;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(posedge i_mclk);
    i_srst <= 0;
    t_switch;
    t_presc;
    t_cfg;
    t_fail;
    close_out;
  end
endmodule : test_system_clock_controller

bind scc_top scc_props u_props (.i_mclk, .i_srst, .i_arvalid, .o_arready, .o_rvalid,
  .o_awready, .o_bvalid, .o_msi_range, .i_osc_tick, .o_sys, .o_kern);

// >>> hw/scc_pkg.sv
/*
 * Constants, field layouts and carrier types of the system clock controller.
 * Assumes a single 250 MHz control clock; oscillators arrive as one-cycle ticks.
 */
// Behaviour
// - master clock comes from fast external, 16 MHz RC, multi-speed RC or PLL.
// - source changes at run time without glitches or lost ticks.
// - separate gates stop core, memory and each peripheral clock.
// - bus and peripheral clocks come from master clock via software prescalers.
// - PLL input selectable among three sources; system PLL output to master clock held to 80 MHz.
// - multi-speed RC has twelve ranges from 100 kHz to 48 MHz.
// - multi-speed RC trimmed in hardware against running slow external clock.
// - trimmed multi-speed RC may clock the USB device.
// - 16 MHz RC and multi-speed RC each take a software trim value.
// - 48 MHz RC selectable for USB, random generator and clock output pin.
// - slow external oscillator has four drive settings and a bypass setting.
// - real-time clock from slow external or slow internal; watchdog from slow internal.
// - kernel clocks for many peripherals independent of master clock choice.
// - two PLLs with three divided outputs each feed ADC, USB/random, audio.
// - after reset master clock runs from multi-speed RC at 4 MHz.
// - fast external loss switches master to 16 MHz RC, optional interrupt.
// - slow external clock failure detected and raises an interrupt.
// - clock output pin carries one selected internal clock.
// - slow output pin carries slow internal or external clock in all modes.
package scc_pkg;

  localparam int unsigned MCLK_MHZ = 250;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PRESC  = 8'h08;
  localparam logic [7:0] OFS_GATE   = 8'h0C;
  localparam logic [7:0] OFS_TRIM   = 8'h10;
  localparam logic [7:0] OFS_PLLCFG = 8'h14;
  localparam logic [7:0] OFS_KSEL   = 8'h18;
  localparam logic [7:0] OFS_FLAGS  = 8'h1C;

  localparam logic [1:0] SRC_FAST = 2'h0;
  localparam logic [1:0] SRC_RC16 = 2'h1;
  localparam logic [1:0] SRC_MSI  = 2'h2;
  localparam logic [1:0] SRC_PLL  = 2'h3;

  // ctrl fields
  localparam int unsigned CT_SRC = 0;
  localparam int unsigned CT_FMON = 2;
  localparam int unsigned CT_SMON = 3;
  localparam int unsigned CT_ATRIM = 4;
  localparam int unsigned CT_FIRQ = 5;
  localparam int unsigned CT_SIRQ = 6;
  localparam int unsigned CT_RANGE = 8;
  // ksel fields
  localparam int unsigned KS_USB = 0;
  localparam int unsigned KS_SAI = 2;
  localparam int unsigned KS_RTC = 3;
  localparam int unsigned KS_DRV = 4;
  localparam int unsigned KS_BYP = 6;
  localparam int unsigned KS_CLKO = 7;
  localparam int unsigned KS_SLO = 10;
  localparam int unsigned KS_KERN = 11;
  // pllcfg fields, trim fields, flag bits
  localparam int unsigned PC_SRC = 0;
  localparam int unsigned PC_DIV = 2;
  localparam int unsigned TR_RC16 = 0;
  localparam int unsigned TR_MSI = 8;
  localparam int unsigned TR_HW = 16;
  localparam int unsigned FL_FAST = 0;
  localparam int unsigned FL_SLOW = 1;
  localparam int unsigned FL_PLL = 2;

  localparam logic [3:0]  RANGE_4MHZ = 4'h6;
  localparam logic [31:0] CTRL_RST  = {20'h0, RANGE_4MHZ, 6'h0, SRC_MSI};
  localparam logic [31:0] PRESC_RST = 32'h0000_0000;
  localparam logic [31:0] GATE_RST  = 32'h0003_FFFF;
  localparam logic [31:0] TRIM_RST  = 32'h0000_8010;
  localparam logic [31:0] PLL_RST   = 32'h0000_0000;
  localparam logic [31:0] KSEL_RST  = 32'h0000_0000;
  localparam logic [7:0]  HW_TRIM_RST = 8'h80;
  localparam logic [3:0]  HPRE_MAX = 4'h9;
  localparam logic [2:0]  PPRE_MAX = 3'h4;

  localparam int unsigned FAST_FAIL_NS  = 1000;
  localparam int unsigned FAST_FAIL_CYC = FAST_FAIL_NS * MCLK_MHZ / 1000;
  localparam int unsigned SLOW_FAIL_NS  = 100000;
  localparam int unsigned SLOW_FAIL_CYC = SLOW_FAIL_NS * MCLK_MHZ / 1000;
  localparam int unsigned PLL_WIN_NS    = 1000;
  localparam int unsigned PLL_WIN_CYC   = PLL_WIN_NS * MCLK_MHZ / 1000;
  localparam int unsigned PLL_MAX_MHZ   = 80;
  localparam int unsigned PLL_MAX_TICKS = PLL_MAX_MHZ * PLL_WIN_NS / 1000;
  localparam int unsigned SLOW_EXT_HZ   = 32768;

  typedef struct packed {
    logic       fast_ext;
    logic       rc16;
    logic       multi_speed_rc;
    logic       rc48;
    logic       slow_ext;
    logic       slow_int;
    logic [1:0] pll_vco;
  } scc_osc_t;

  typedef struct packed {
    logic master;
    logic bus;
    logic core;
    logic mem;
    logic peripheral_bus_clock_one;
    logic peripheral_bus_clock_two;
    logic tim1;
    logic tim2;
  } scc_sys_t;

  typedef struct packed {
    logic usb_rng;
    logic serial_audio_interface;
    logic adc;
    logic uart;
    logic i2c;
    logic lptim;
    logic single_wire_interface;
    logic rtc;
    logic wdg;
  } scc_kern_t;

  // multi-speed RC ticks expected per slow external period, per range
  function automatic logic [11:0] msi_per_slow(input logic [3:0] range);
    int unsigned khz;
    unique case (range)
      4'h0: khz = 100;
      4'h1: khz = 200;
      4'h2: khz = 400;
      4'h3: khz = 800;
      4'h4: khz = 1000;
      4'h5: khz = 2000;
      4'h6: khz = 4000;
      4'h7: khz = 8000;
      4'h8: khz = 16000;
      4'h9: khz = 24000;
      4'hA: khz = 32000;
      default: khz = 48000;
    endcase
    return 12'(khz * 1000 / SLOW_EXT_HZ);
  endfunction : msi_per_slow

endpackage : scc_pkg

// >>> hw/scc_top.sv
/*
 * System clock controller: source mux, prescalers, gating, PLL output dividers,
 * kernel clock selection, failure monitors and AXI4-Lite register slave.
 * Assumes every oscillator and PLL VCO is presented as a tick synchronous to i_mclk.
 */
`timescale 1ns/10ps
module scc_top import scc_pkg::*; #(
  parameter int unsigned SLOW_FAIL_CYCLES = SLOW_FAIL_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  scc_osc_t         i_osc_tick,
  input  scc_osc_t         i_osc_ready,
  output scc_sys_t         o_sys,
  output scc_kern_t        o_kern,
  output logic [15:0]      o_periph_tick,
  output logic             o_clk_out_pin,
  output logic             o_slow_out_pin,
  output logic             o_fail_irq,
  output logic [3:0]       o_msi_range,
  output logic [7:0]       o_msi_trim,
  output logic [4:0]       o_rc16_trim,
  output logic [1:0]       o_slow_ext_drive,
  output logic             o_slow_ext_bypass,
  output logic [1:0]       o_pll_src
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= OFS_FLAGS;
  endfunction : mapped

  logic [31:0] ctrl, presc, gate, trim, pllcfg, ksel;
  logic [2:0]  flags;
  logic [1:0]  cur_src;
  logic [7:0]  hw_trim;
  logic        msi_locked;
  logic        aw_got, w_got;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        fast_evt, slow_evt, pll_evt;
  logic [5:0]  pll_out;
  logic        sys_pll_tick;

  // AXI4-Lite write path: address and data taken in either order
  wire do_wr = aw_got && w_got && !o_bvalid;
  wire wr_ok = mapped(aw_addr);

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      aw_got    <= 1'b0;
      w_got     <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
    end else begin
      o_awready <= !aw_got && !(o_awready && i_awvalid);
      o_wready  <= !w_got && !(o_wready && i_wvalid);
      if (o_awready && i_awvalid) begin
        aw_got  <= 1'b1;
        aw_addr <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_got  <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
      end
      if (do_wr) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_ok ? 2'h0 : 2'h2;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_got   <= 1'b0;
        w_got    <= 1'b0;
      end
    end
  end

  // software registers
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      ctrl   <= CTRL_RST;
      presc  <= PRESC_RST;
      gate   <= GATE_RST;
      trim   <= TRIM_RST;
      pllcfg <= PLL_RST;
      ksel   <= KSEL_RST;
    end else begin
      if (do_wr) begin
        unique case (aw_addr)
          OFS_CTRL:   ctrl   <= merge(ctrl, w_data, w_strb);
          OFS_PRESC:  presc  <= merge(presc, w_data, w_strb);
          OFS_GATE:   gate   <= merge(gate, w_data, w_strb);
          OFS_TRIM:   trim   <= merge(trim, w_data, w_strb);
          OFS_PLLCFG: pllcfg <= merge(pllcfg, w_data, w_strb);
          OFS_KSEL:   ksel   <= merge(ksel, w_data, w_strb);
          default: ;
        endcase
      end
      // a failure overrides a same-cycle software choice of source
      if (fast_evt) ctrl[CT_SRC +: 2] <= SRC_RC16;
    end
  end

  // flags: set wins over write-one-to-clear
  wire [2:0] flag_clr = (do_wr && aw_addr == OFS_FLAGS && w_strb[0]) ? w_data[2:0] : 3'h0;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      flags <= 3'h0;
    end else begin
      flags <= (flags & ~flag_clr) | {pll_evt, slow_evt, fast_evt};
    end
  end

  // read path
  logic [31:0] rd_val;
  always_comb begin
    unique case (i_araddr)
      OFS_CTRL:   rd_val = ctrl;
      OFS_STATUS: rd_val = {18'h0, ctrl[CT_SRC +: 2] != cur_src, msi_locked,
                            i_osc_ready, 2'h0, cur_src};
      OFS_PRESC:  rd_val = presc;
      OFS_GATE:   rd_val = gate;
      OFS_TRIM:   rd_val = {8'h0, hw_trim, trim[15:0]};
      OFS_PLLCFG: rd_val = pllcfg;
      OFS_KSEL:   rd_val = ksel;
      OFS_FLAGS:  rd_val = {29'h0, flags};
      default:    rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= 2'h0;
    end else begin
      o_arready <= !o_rvalid && !(o_arready && i_arvalid);
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rdata  <= mapped(i_araddr) ? rd_val : 32'h0000_0000;
        o_rresp  <= mapped(i_araddr) ? 2'h0 : 2'h2;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // two PLLs, three divided outputs each, divide by field plus one
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_plldiv
      logic [2:0] cnt;
      wire  [2:0] lim = pllcfg[PC_DIV + 3*g +: 3];
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          cnt        <= 3'h0;
          pll_out[g] <= 1'b0;
        end else begin
          pll_out[g] <= i_osc_tick.pll_vco[g/3] && cnt == lim;
          if (i_osc_tick.pll_vco[g/3]) cnt <= (cnt == lim) ? 3'h0 : cnt + 3'h1;
        end
      end
    end
  endgenerate

  // system PLL rate watch: count ticks per 1 us window, block above the limit
  logic [7:0] win_cnt, pll_cnt;
  logic       pll_ok;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      win_cnt <= 8'h00;
      pll_cnt <= 8'h00;
      pll_ok  <= 1'b1;
      pll_evt <= 1'b0;
    end else begin
      pll_evt <= 1'b0;
      if (win_cnt == 8'(PLL_WIN_CYC - 1)) begin
        win_cnt <= 8'h00;
        pll_cnt <= 8'h00;
        pll_ok  <= pll_cnt <= 8'(PLL_MAX_TICKS);
        pll_evt <= pll_cnt > 8'(PLL_MAX_TICKS);
      end else begin
        win_cnt <= win_cnt + 8'h01;
        if (pll_out[0] && pll_cnt != 8'hFF) pll_cnt <= pll_cnt + 8'h01;
      end
    end
  end
  assign sys_pll_tick = pll_out[0] && pll_ok;

  function automatic logic src_tick(input logic [1:0] s, input scc_osc_t t, input logic p);
    unique case (s)
      SRC_FAST: return t.fast_ext;
      SRC_RC16: return t.rc16;
      SRC_MSI:  return t.multi_speed_rc;
      default:  return p;
    endcase
  endfunction : src_tick

  function automatic logic src_ready(input logic [1:0] s, input scc_osc_t r, input logic ok);
    unique case (s)
      SRC_FAST: return r.fast_ext;
      SRC_RC16: return r.rc16;
      SRC_MSI:  return r.multi_speed_rc;
      default:  return r.pll_vco[0] && ok;
    endcase
  endfunction : src_ready

  // source switch just after a tick of the old source, or at once on fast external loss, so no tick is cut or lost
  wire [1:0] req_src = ctrl[CT_SRC +: 2];
  wire cur_tick = src_tick(cur_src, i_osc_tick, sys_pll_tick);
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cur_src <= SRC_MSI;
    end else if (fast_evt && cur_src == SRC_FAST) begin
      cur_src <= SRC_RC16;
    end else if (req_src != cur_src && cur_tick
                 && src_ready(req_src, i_osc_ready, pll_ok)) begin
      cur_src <= req_src;
    end
  end

  // prescalers
  logic [8:0] hcnt;
  logic [3:0] pcnt [2];
  wire  [3:0] hpre = (presc[3:0] > HPRE_MAX) ? HPRE_MAX : presc[3:0];
  wire  [8:0] hmask = 9'((10'h001 << hpre) - 10'h001);
  wire        next_master = cur_tick;
  wire        next_bus = o_sys.master && hcnt == hmask;
  logic [1:0] next_pclk, next_tim;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      hcnt <= 9'h000;
    end else if (o_sys.master) begin
      hcnt <= (hcnt == hmask) ? 9'h000 : hcnt + 9'h001;
    end
  end

  generate
    for (g = 0; g < 2; g++) begin : g_pbus
      wire [2:0] raw = presc[4 + 3*g +: 3];
      wire [2:0] ppre = (raw > PPRE_MAX) ? PPRE_MAX : raw;
      wire [3:0] pmask = 4'((5'h01 << ppre) - 5'h01);
      wire [3:0] half = pmask >> 1;
      assign next_pclk[g] = next_bus && pcnt[g] == pmask;
      // x1 timer at divide 1, else ticks twice per peripheral bus period
      assign next_tim[g] = (ppre == 3'h0) ? next_bus
                         : next_bus && (pcnt[g] & half) == half;
      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          pcnt[g] <= 4'h0;
        end else if (next_bus) begin
          pcnt[g] <= (pcnt[g] == pmask) ? 4'h0 : pcnt[g] + 4'h1;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_sys         <= '0;
      o_periph_tick <= 16'h0000;
    end else begin
      o_sys.master  <= next_master;
      o_sys.bus     <= next_bus;
      o_sys.core    <= next_bus && gate[0];
      o_sys.mem     <= next_bus && gate[1];
      o_sys.peripheral_bus_clock_one   <= next_pclk[0];
      o_sys.peripheral_bus_clock_two   <= next_pclk[1];
      o_sys.tim1    <= next_tim[0];
      o_sys.tim2    <= next_tim[1];
      o_periph_tick <= {{8{next_pclk[1]}}, {8{next_pclk[0]}}} & gate[17:2];
    end
  end

  // failure monitors: a missing tick for the timeout counts as loss
  logic [7:0]  fcnt;
  logic [31:0] scnt;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fcnt     <= 8'h00;
      scnt     <= 32'h0;
      fast_evt <= 1'b0;
      slow_evt <= 1'b0;
    end else begin
      fast_evt <= ctrl[CT_FMON] && i_osc_ready.fast_ext && !i_osc_tick.fast_ext
                  && fcnt == 8'(FAST_FAIL_CYC - 1);
      slow_evt <= ctrl[CT_SMON] && i_osc_ready.slow_ext && !i_osc_tick.slow_ext
                  && scnt == SLOW_FAIL_CYCLES - 1;
      if (i_osc_tick.fast_ext || !ctrl[CT_FMON]) fcnt <= 8'h00;
      else if (fcnt != 8'(FAST_FAIL_CYC)) fcnt <= fcnt + 8'h01;
      if (i_osc_tick.slow_ext || !ctrl[CT_SMON]) scnt <= 32'h0;
      else if (scnt != SLOW_FAIL_CYCLES) scnt <= scnt + 32'h1;
    end
  end

  // hardware trim of the multi-speed RC against the slow external clock
  logic [11:0] mcnt;
  wire  [11:0] m_exp = msi_per_slow(ctrl[CT_RANGE +: 4]);
  wire         trim_on = ctrl[CT_ATRIM] && i_osc_ready.slow_ext && !flags[FL_SLOW];
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mcnt       <= 12'h000;
      hw_trim    <= HW_TRIM_RST;
      msi_locked <= 1'b0;
    end else if (!trim_on) begin
      mcnt       <= 12'h000;
      msi_locked <= 1'b0;
    end else if (i_osc_tick.slow_ext) begin
      mcnt       <= 12'h000;
      msi_locked <= mcnt + 12'h001 >= m_exp && mcnt <= m_exp + 12'h001;
      if (mcnt < m_exp && hw_trim != 8'hFF) hw_trim <= hw_trim + 8'h01;
      else if (mcnt > m_exp && hw_trim != 8'h00) hw_trim <= hw_trim - 8'h01;
    end else if (i_osc_tick.multi_speed_rc && mcnt != 12'hFFF) begin
      mcnt <= mcnt + 12'h001;
    end
  end

  // kernel clocks, independent of the master clock source
  function automatic logic kern_src(input logic [1:0] s, input logic pclk,
                                    input logic mst, input scc_osc_t t);
    unique case (s)
      2'h0:    return pclk;
      2'h1:    return mst;
      2'h2:    return t.rc16;
      default: return t.slow_ext;
    endcase
  endfunction : kern_src

  logic usb_src, clko_src;
  always_comb begin
    unique case (ksel[KS_USB +: 2])
      2'h0:    usb_src = pll_out[1];
      2'h1:    usb_src = pll_out[4];
      2'h2:    usb_src = i_osc_tick.multi_speed_rc && msi_locked;
      default: usb_src = i_osc_tick.rc48;
    endcase
    unique case (ksel[KS_CLKO +: 3])
      3'h0:    clko_src = next_master;
      3'h1:    clko_src = i_osc_tick.rc16;
      3'h2:    clko_src = i_osc_tick.multi_speed_rc;
      3'h3:    clko_src = i_osc_tick.fast_ext;
      3'h4:    clko_src = sys_pll_tick;
      3'h5:    clko_src = i_osc_tick.slow_int;
      3'h6:    clko_src = i_osc_tick.slow_ext;
      default: clko_src = i_osc_tick.rc48;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_kern         <= '0;
      o_clk_out_pin  <= 1'b0;
      o_slow_out_pin <= 1'b0;
    end else begin
      o_kern.usb_rng <= usb_src;
      o_kern.serial_audio_interface     <= ksel[KS_SAI] ? pll_out[3] : pll_out[2];
      o_kern.adc     <= pll_out[5];
      o_kern.uart    <= kern_src(ksel[KS_KERN +: 2], next_pclk[0], next_master, i_osc_tick);
      o_kern.i2c     <= kern_src(ksel[KS_KERN+2 +: 2], next_pclk[0], next_master, i_osc_tick);
      o_kern.lptim   <= kern_src(ksel[KS_KERN+4 +: 2], next_pclk[0], next_master, i_osc_tick);
      o_kern.single_wire_interface   <= kern_src(ksel[KS_KERN+6 +: 2], next_pclk[0], next_master, i_osc_tick);
      o_kern.rtc     <= ksel[KS_RTC] ? i_osc_tick.slow_int : i_osc_tick.slow_ext;
      o_kern.wdg     <= i_osc_tick.slow_int;
      o_clk_out_pin  <= clko_src;
      // never gated, so it keeps running in every low-power mode
      o_slow_out_pin <= ksel[KS_SLO] ? i_osc_tick.slow_ext : i_osc_tick.slow_int;
    end
  end

  // oscillator controls and interrupt
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_fail_irq        <= 1'b0;
      o_msi_range       <= RANGE_4MHZ;
      o_msi_trim        <= TRIM_RST[TR_MSI +: 8];
      o_rc16_trim       <= TRIM_RST[TR_RC16 +: 5];
      o_slow_ext_drive  <= 2'h0;
      o_slow_ext_bypass <= 1'b0;
      o_pll_src         <= 2'h0;
    end else begin
      o_fail_irq        <= (flags[FL_FAST] && ctrl[CT_FIRQ])
                           || (flags[FL_SLOW] && ctrl[CT_SIRQ]);
      o_msi_range       <= ctrl[CT_RANGE +: 4];
      o_msi_trim        <= trim_on ? hw_trim : trim[TR_MSI +: 8];
      o_rc16_trim       <= trim[TR_RC16 +: 5];
      o_slow_ext_drive  <= ksel[KS_DRV +: 2];
      o_slow_ext_bypass <= ksel[KS_BYP];
      o_pll_src         <= (pllcfg[PC_SRC +: 2] == 2'h3) ? 2'h2 : pllcfg[PC_SRC +: 2];
    end
  end

endmodule : scc_top
